/* dv/pwmcc_props.sv */
/* Checker on the channel's bus and waveform ports.
   Assumes one clock; shadows bus writes since it sees no internal state. */
`timescale 1ns/1ps
module pwmcc_props
  import pwmcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        wave_in,
  input wire logic        wave_out
);
  logic [31:0] ctl_sh;
  logic [31:0] duty_sh;
  logic [31:0] hi_cnt;
  logic        wr_ph;
  logic [7:0]  wr_ofs;
  wire         rd_take = hsel && htrans[1] && hready && !hwrite;
  // Only the fastest plain setting: freeze or mid-period duty writes would mislead the shadow
  wire         fast = ctl_sh[6:0] == 7'h0B && ctl_sh[14:12] == 3'h0 && !ctl_sh[9];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_ph, wr_ofs, ctl_sh, duty_sh, hi_cnt} <= '0;
    end else begin
      wr_ph  <= hsel && htrans[1] && hready && hwrite;
      wr_ofs <= haddr[7:0];
      if (wr_ph && wr_ofs == OFS_CTRL) ctl_sh <= hwdata;
      if (wr_ph && wr_ofs == OFS_DUTY) duty_sh <= hwdata;
      hi_cnt <= wave_out ? hi_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ctl_on;
    wr_ph && wr_ofs == OFS_CTRL && hwdata[0] && hwdata[2:1] == MODE_CONT && !hwdata[5] && !ctl_sh[0];
  endsequence
  sequence idle_q;
    $stable(ctl_sh) && (!ctl_sh[0] || ctl_sh[2]);
  endsequence
  okay_resp_a: assert property (hresp == 1'b0) else $error("bus response not OKAY");
  zero_wait_a: assert property (hreadyout == 1'b1) else $error("bus wait state seen");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved");
  resv_zero_a: assert property (rd_take && haddr[7:0] == OFS_CTRL |=> (hrdata & 32'h0000_8C80) == 0)
    else $error("reserved control bits not zero");
  unmapped_a: assert property (rd_take && !(haddr[7:0] inside {8'h28, 8'h2C, 8'h30, 8'h34})
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  idle_lvl_a: assert property (idle_q [*3] |-> wave_out == ctl_sh[4])
    else $error("idle output level wrong");
  act_start_a: assert property (ctl_on |-> ##[1:4] wave_out == ctl_sh[3])
    else $error("period did not open with duty level");
  duty_len_a: assert property ($fell(wave_out) && fast |-> hi_cnt == duty_sh)
    else $error("duty portion length wrong");
endmodule

/* dv/pwmcc_wave_src.sv */
/* Partner: square-wave source on the capture input pin.
   Assumes the bench clock; held low when off, as a pull-down would hold it. */
`timescale 1ns/1ps
module pwmcc_wave_src (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] hi_len,
  input  wire logic [15:0] lo_len,
  output logic             wave
);
  logic [15:0] n;
  wire  [15:0] len = wave ? hi_len : lo_len;
  always_ff @(posedge clk) begin
    if (!en) begin
      wave <= 1'b0;
      n    <= 16'h0;
    end else if (n + 16'h1 >= len) begin
      wave <= ~wave;
      n    <= 16'h0;
    end else begin
      n <= n + 16'h1;
    end
  end
endmodule

/* dv/tb_top.sv */
/* Top testbench: AHB-Lite master tasks, one task per scenario.
   Assumes hready tied to hreadyout and the square-wave partner on the input pin. */
`timescale 1ns/1ps
module tb_top;
  import pwmcc_pkg::*;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, wave_in, wave_out, src_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] hi_len, lo_len;
  int          errors, cmp_count, cyc;
  pwmcc_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wave_in(wave_in), .wave_out(wave_out));
  pwmcc_wave_src u_src (.clk(clk), .en(src_en), .hi_len(hi_len), .lo_len(lo_len), .wave(wave_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // Skips the first pulse, whose prescaler phase is not aligned
  task automatic meas(output int hi, output int per);
    while (wave_out !== 1'b1) @(posedge clk);
    while (wave_out !== 1'b0) @(posedge clk);
    while (wave_out !== 1'b1) @(posedge clk);
    hi = 0;
    while (wave_out === 1'b1) begin
      @(posedge clk);
      hi++;
    end
    per = hi;
    while (wave_out === 1'b0) begin
      @(posedge clk);
      per++;
    end
  endtask
  task automatic run(input logic [31:0] p, input logic [31:0] d, input logic [31:0] c,
                     input logic [31:0] eh, input logic [31:0] ep);
    int hi, per;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PERIOD, p);
    wr(OFS_DUTY, d);
    wr(OFS_CTRL, c);
    meas(hi, per);
    chk("high time", 32'(hi), eh);
    chk("period", 32'(per), ep);
  endtask
  task automatic t_regs;
    rd("ctrl reset", OFS_CTRL, 32'h0);
    rd("duty reset", OFS_DUTY, 32'h0);
    rd("period reset", OFS_PERIOD, 32'h0);
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd("ctrl access", OFS_CTRL, 32'hFFFF_737F);
    repeat (6) @(posedge clk);
    chk("reserved mode idle", {31'h0, wave_out}, 32'h1);
    rd("unmapped", 8'h40, 32'h0);
    wr(OFS_CTRL, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_out;
    logic [31:0] q;
    int hi, per;
    run(32'hA, 32'h3, 32'h0000_010B, 32'h3, 32'hA);
    bus(1'b0, OFS_TALLY, 32'h0, q);
    chk("tally range", {31'h0, q < 32'hA}, 32'h1);
    run(32'h9, 32'h4, 32'h0000_002B, 32'h4, 32'h8);
    run(32'hA, 32'h3, 32'h0000_004B, 32'h3, 32'hA);
    wr(OFS_DUTY, 32'h6);
    meas(hi, per);
    chk("frozen high", 32'(hi), 32'h3);
    chk("frozen period", 32'(per), 32'hA);
    run(32'hA, 32'h6, 32'h0000_000B, 32'h6, 32'hA);
    $display("test output done");
  endtask
  task automatic t_scale;
    logic [2:0]  pre_t [3] = '{3'h2, 3'h0, 3'h1};
    logic [7:0]  sc_t  [3] = '{8'h1, 8'h0, 8'h3};
    logic [31:0] e;
    for (int i = 0; i < 3; i++) begin
      e = (32'h1 << pre_t[i]) * 32'h2 * (sc_t[i] == 8'h0 ? 32'h100 : {24'h0, sc_t[i]});
      run(32'h2, 32'h1, {8'h0, sc_t[i], 1'b0, pre_t[i], 12'h20B}, e, e * 32'h2);
    end
    $display("test scale done");
  endtask
  task automatic t_oneshot;
    int n;
    logic prev;
    n = 0;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PERIOD, 32'h4);
    wr(OFS_DUTY, 32'h2);
    prev = wave_out;
    wr(OFS_CTRL, 32'h0200_0009);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      if (wave_out === 1'b1 && prev === 1'b0) n++;
      prev = wave_out;
    end
    chk("one-shot pulses", 32'(n), 32'h3);
    rd("self clear", OFS_CTRL, 32'h0200_0008);
    chk("done level", {31'h0, wave_out}, 32'h0);
    $display("test one-shot done");
  endtask
  task automatic t_capt;
    hi_len <= 16'h14;
    lo_len <= 16'h1E;
    src_en <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0015);
    repeat (200) @(posedge clk);
    rd("high capture", OFS_PERIOD, 32'h14);
    rd("low capture", OFS_DUTY, 32'h1E);
    chk("capture level", {31'h0, wave_out}, 32'h1);
    src_en <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    $display("test capture done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    {rst_n, hsel, hwrite, src_en, htrans, haddr, hwdata, hi_len, lo_len} = '0;
    errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_out;
    t_scale;
    t_oneshot;
    t_capt;
    close_out;
  end
endmodule
bind pwmcc_top pwmcc_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wave_in(wave_in),
  .wave_out(wave_out));

/* hw/pwmcc_pkg.sv */
/*
  Package for the single-channel pulse-width generator with capture:
  register offsets, control field positions, reset values, mode codes.
  Assumes a 32-bit AHB-Lite register bus and one 10 MHz clock.
*/
// Behaviour
// - One-shot emits repeat count plus one whole periods; count in control bits 31:24.
// - Scaled clock is prescaled clock over twice divider factor; zero means 256.
// - Prescaled clock is input clock divided by two to the 3-bit power.
// - Source pick 0 uses prescaled clock, 1 uses further scaled clock.
// - Idle clock gate blocks prescaler clocking while channel is inactive.
// - Settings freeze keeps earlier period and duty instead of newly written ones.
// - Alignment select 0 gives left-aligned, 1 centre-aligned waveform.
// - Inactive channel drives output at idle level select polarity.
// - Each period starts with duty portion at active level select polarity.
// - Operation select: 00 one-shot, 01 continuous, 10 capture, 11 reserved.
// - One-shot completion clears channel on bit by hardware.
// - Read-only 32-bit running tally advances at channel clock rate.
// - Output modes use period value in channel clocks as period.
// - Centre-aligned mode ignores period bit 0.
// - Capture writes measured high-level cycles into period register.
// - Duty register gives duty length; capture writes low-level cycles into it.
package pwmcc_pkg;
  localparam logic [7:0]  OFS_DUTY    = 8'h28;
  localparam logic [7:0]  OFS_CTRL    = 8'h2C;
  localparam logic [7:0]  OFS_TALLY   = 8'h30;
  localparam logic [7:0]  OFS_PERIOD  = 8'h34;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK  = 32'hFFFF_737F;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  localparam int          F_RPT_LO    = 24;
  localparam int          F_SCALE_LO  = 16;
  localparam int          F_PRE_LO    = 12;
  localparam int          F_SRC       = 9;
  localparam int          F_GATE      = 8;
  localparam int          F_FREEZE    = 6;
  localparam int          F_ALIGN     = 5;
  localparam int          F_IDLE_POL  = 4;
  localparam int          F_ACT_POL   = 3;
  localparam int          F_MODE_LO   = 1;
  localparam int          F_ON        = 0;
  localparam logic [1:0]  MODE_ONESHOT = 2'b00;
  localparam logic [1:0]  MODE_CONT    = 2'b01;
  localparam logic [1:0]  MODE_CAPT    = 2'b10;
  localparam logic [8:0]  SCALE_ZERO_DIV = 9'h100;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_CAPT = 2'b11
  } pwmcc_state_t;
endpackage

/* hw/pwmcc_top.sv */
/*
  Pulse-width channel with capture: AHB-Lite register slave, clock
  prescaler and scaler, output waveform engine, input level timer.
  Assumes one clock; the waveform input pin is asynchronous.
*/
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pwmcc_top
  import pwmcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wave_in,
  output logic             wave_out
);

  logic        rst_s1;
  logic        srst_n;
  logic [31:0] ctrl;
  logic [31:0] duty_reg;
  logic [31:0] period_reg;
  logic [31:0] tally;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] per_act;
  logic [31:0] duty_act;
  logic [7:0]  rep_cnt;
  logic [6:0]  pre_cnt;
  logic [8:0]  scl_cnt;
  logic        in_s1;
  logic        in_s2;
  logic        in_s3;
  logic [31:0] lev_cnt;
  pwmcc_state_t state;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      srst_n <= rst_s1;
    end
  end

  wire [7:0] rpt      = ctrl[F_RPT_LO +: 8];
  wire [7:0] scale    = ctrl[F_SCALE_LO +: 8];
  wire [2:0] pre_pow  = ctrl[F_PRE_LO +: 3];
  wire       src_pick = ctrl[F_SRC];
  wire       gate_on  = ctrl[F_GATE];
  wire       freeze   = ctrl[F_FREEZE];
  wire       centre   = ctrl[F_ALIGN];
  wire       idle_pol = ctrl[F_IDLE_POL];
  wire       act_pol  = ctrl[F_ACT_POL];
  wire [1:0] mode     = ctrl[F_MODE_LO +: 2];
  wire       chan_on  = ctrl[F_ON];

  // Bus decode: address phase accepted when the bus is ready
  wire       addr_ok  = hsel & htrans[1] & hready;
  wire       rd_take  = addr_ok & ~hwrite;
  wire       wr_take  = addr_ok & hwrite;
  wire [7:0] a_ofs    = haddr[7:0];
  wire       wr_ctrl  = wr_pend & (wr_addr == OFS_CTRL);
  wire       wr_duty  = wr_pend & (wr_addr == OFS_DUTY);
  wire       wr_per   = wr_pend & (wr_addr == OFS_PERIOD);
  wire       hit_duty = a_ofs == OFS_DUTY;
  wire       hit_ctrl = a_ofs == OFS_CTRL;
  wire       hit_tal  = a_ofs == OFS_TALLY;
  wire       hit_per  = a_ofs == OFS_PERIOD;
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_duty) begin
      rd_mux = duty_reg;
    end else if (hit_ctrl) begin
      rd_mux = ctrl;
    end else if (hit_tal) begin
      rd_mux = tally;
    end else if (hit_per) begin
      rd_mux = period_reg;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Clock dividers as one-cycle enables
  wire active   = (state != ST_IDLE);
  wire pre_run  = ~(gate_on & ~active);
  wire [6:0] pre_last = 7'((8'h01 << pre_pow) - 8'h01);
  wire pre_tick = pre_run & (pre_cnt >= pre_last);
  wire [8:0] scl_div  = (scale == 8'h00) ? SCALE_ZERO_DIV : {1'b0, scale};
  wire [8:0] scl_last = 9'((scl_div << 1) - 10'h001);
  wire scl_tick = pre_tick & (scl_cnt >= scl_last);
  wire ch_tick  = src_pick ? scl_tick : pre_tick;

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pre_cnt <= 7'h00;
      scl_cnt <= 9'h000;
    end else if (pre_run) begin
      pre_cnt <= pre_tick ? 7'h00 : 7'(pre_cnt + 7'h01);
      if (pre_tick) begin
        scl_cnt <= scl_tick ? 9'h000 : 9'(scl_cnt + 9'h001);
      end
    end
  end

  // Waveform timing
  wire [31:0] per_eff  = centre ? {per_act[31:1], 1'b0} : per_act;
  wire [31:0] half_d   = {1'b0, duty_act[31:1]};
  wire        at_end   = (per_eff == 32'h0000_0000) | (tally >= 32'(per_eff - 32'h1));
  wire        in_duty  = centre ? ((tally < half_d) | (tally >= 32'(per_eff - half_d)))
                                : (tally < duty_act);
  wire        out_mode = (mode == MODE_ONESHOT) | (mode == MODE_CONT);
  wire        shot_end = (state == ST_RUN) & ch_tick & at_end
                         & (mode == MODE_ONESHOT) & (rep_cnt == rpt);
  wire        lev_end  = (state == ST_CAPT) & (in_s2 != in_s3);

  // Registers: bus writes and hardware updates
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= DATA_RESET;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      ctrl       <= CTRL_RESET;
      duty_reg   <= DATA_RESET;
      period_reg <= DATA_RESET;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= a_ofs;
      if (rd_take) begin
        hrdata <= rd_mux;
      end
      // Software write beats the self-clear so a restart is not lost
      if (wr_ctrl) begin
        ctrl <= hwdata & CTRL_WMASK;
      end else if (shot_end) begin
        ctrl[F_ON] <= 1'b0;
      end
      // Capture results win over a colliding software write
      if (lev_end & ~in_s3) begin
        duty_reg <= lev_cnt;
      end else if (wr_duty) begin
        duty_reg <= hwdata;
      end
      if (lev_end & in_s3) begin
        period_reg <= lev_cnt;
      end else if (wr_per) begin
        period_reg <= hwdata;
      end
    end
  end

  // Input synchroniser; the first stage feeds only the second
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_s3 <= 1'b0;
    end else begin
      in_s1 <= wave_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // Channel engine
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state    <= ST_IDLE;
      tally    <= 32'h0000_0000;
      per_act  <= DATA_RESET;
      duty_act <= DATA_RESET;
      rep_cnt  <= 8'h00;
      lev_cnt  <= 32'h0000_0000;
      wave_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          wave_out <= idle_pol;
          tally    <= 32'h0000_0000;
          rep_cnt  <= 8'h00;
          lev_cnt  <= 32'h0000_0000;
          if (chan_on & out_mode) begin
            state    <= ST_RUN;
            per_act  <= period_reg;
            duty_act <= duty_reg;
          end else if (chan_on & (mode == MODE_CAPT)) begin
            state <= ST_CAPT;
          end
        end
        ST_RUN: begin
          if (!chan_on | !out_mode | shot_end) begin
            state    <= ST_IDLE;
            wave_out <= idle_pol;
          end else begin
            wave_out <= in_duty ? act_pol : ~act_pol;
            if (ch_tick) begin
              if (at_end) begin
                tally   <= 32'h0000_0000;
                rep_cnt <= 8'(rep_cnt + 8'h01);
                // Frozen settings keep the old waveform until unlocked
                if (!freeze) begin
                  per_act  <= period_reg;
                  duty_act <= duty_reg;
                end
              end else begin
                tally <= 32'(tally + 32'h1);
              end
            end
          end
        end
        ST_CAPT: begin
          wave_out <= idle_pol;
          if (!chan_on | (mode != MODE_CAPT)) begin
            state <= ST_IDLE;
          end else begin
            if (ch_tick) begin
              tally <= 32'(tally + 32'h1);
            end
            // A level that spans no channel clock tick reads as zero
            // The edge cycle already belongs to the new level
            if (lev_end) begin
              lev_cnt <= ch_tick ? 32'h0000_0001 : 32'h0000_0000;
            end else if (ch_tick) begin
              lev_cnt <= 32'(lev_cnt + 32'h1);
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
